// File: hw/pll_clock_pkg.sv
package pll_clock_pkg;

  // ********************************************************************
  // register offsets (byte addresses)
  // ********************************************************************
  localparam logic [11:0] OFS_PLL_CTRL    = 12'h000;
  localparam logic [11:0] OFS_PLL_STATUS  = 12'h004;
  localparam logic [11:0] OFS_DIV_CTRL    = 12'h008;
  localparam logic [11:0] OFS_CSEL_SELECT = 12'h00C;
  localparam logic [11:0] OFS_QUAD_ROUTE  = 12'h010;
  localparam logic [11:0] OFS_LINE_STATUS = 12'h020;

  // ********************************************************************
  // field positions
  // ********************************************************************
  localparam int PLL_RESET_BIT    = 0;
  localparam int K_RESET_BIT      = 1;
  localparam int FB_SEL_LSB       = 2;
  localparam int K_RATIO_LSB      = 4;
  localparam int DIV_FIELD_W      = 8;
  localparam int DIV_RATIO_LSB    = 0;
  localparam int DIV_SRC_BIT      = 2;
  localparam int DIV_RESET_BIT    = 3;
  localparam int DIV_RELEASE_BIT  = 4;
  localparam int DIV_HELD_BIT     = 5;
  localparam int ROUTE_ALT_LSB    = 24;

  // ********************************************************************
  // sizes
  // ********************************************************************
  localparam int NUM_QUADS    = 4;
  localparam int NUM_LINES    = 8;
  localparam int NUM_DIVIDERS = 2;
  localparam int NUM_CSEL     = 8;
  localparam int CSEL_FIRST_LINE = 6;

  // ********************************************************************
  // values after reset and counts
  // ********************************************************************
  localparam logic       PLL_RESET_INIT = 1'b0;
  localparam logic       K_RESET_INIT   = 1'b0;
  localparam logic [3:0] K_RATIO_INIT   = 4'h0;
  localparam logic       DIV_HELD_INIT  = 1'b1;
  localparam logic [3:0] LOCK_EDGES     = 4'h8;
  localparam logic [1:0] DIV3_LAST      = 2'h2;

  // ********************************************************************
  // enumerations
  // ********************************************************************
  typedef enum logic [1:0] {FB_INTERNAL, FB_CLOCK_NET, FB_USER, FB_RESERVED} feedback_sel_t;
  typedef enum logic [1:0] {RATIO_DIV2, RATIO_DIV4, RATIO_DIV8} div_ratio_t;
  typedef enum logic {CSEL_FOLLOW, CSEL_GATED} csel_state_t;
  typedef enum logic [2:0] {
    SRC_PRIMARY, SRC_ADJUSTED, SRC_SECONDARY, SRC_DIV3,
    SRC_DIVIDER_LEFT, SRC_DIVIDER_RIGHT, SRC_EDGE_LEFT, SRC_EDGE_RIGHT
  } clock_source_t;

endpackage

// File: hw/pll_divider_clock_select.sv
module pll_divider_clock_select
  import pll_clock_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        pll_reference_in,
  input  wire logic        pll_feedback_in,
  input  wire logic [1:0]  edge_fast_clock,
  input  wire logic [3:0]  dynamic_phase_adjust,
  input  wire logic [3:0]  dynamic_duty_select,
  input  wire logic        fine_delay_adjust,
  output logic             pll_primary_out,
  output logic             pll_adjusted_out,
  output logic             pll_secondary_divided_out,
  output logic             pll_div3_out,
  output logic             pll_lock,
  output logic [1:0]       divider_out,
  output logic [31:0]      primary_lines
);

  // ********************************************************************
  // state
  // ********************************************************************
  typedef struct packed {
    logic [1:0]                   ref_sync;
    logic [1:0]                   fb_sync;
    logic [1:0][1:0]              edge_sync;
    logic                         ref_prev;
    logic                         fb_prev;
    logic                         primary_prev;
    logic [1:0]                   div_src_prev;
    logic                         pll_reset;
    logic                         k_reset;
    logic [1:0]                   fb_sel;
    logic [3:0]                   k_ratio;
    logic [3:0]                   phase_cnt;
    logic                         primary;
    logic                         clock_net;
    logic                         adjusted_raw;
    logic                         adjusted;
    logic [3:0]                   k_cnt;
    logic                         secondary;
    logic [1:0]                   div3_cnt;
    logic                         div3;
    logic [3:0]                   lock_cnt;
    logic                         fb_seen;
    logic                         lock;
    logic [1:0][1:0]              div_ratio;
    logic [1:0]                   div_src;
    logic [1:0]                   div_reset;
    logic [1:0]                   div_held;
    logic [1:0][2:0]              div_cnt;
    logic [1:0]                   div_out;
    logic [7:0]                   csel_sel;
    logic [7:0]                   csel_cur;
    logic [7:0]                   csel_armed;
    csel_state_t [7:0]            csel_state;
    logic [7:0]                   csel_out;
    logic [3:0][7:0][2:0]         line_sel;
    logic [3:0][1:0][2:0]         alt_sel;
    logic [31:0]                  lines;
    logic [31:0]                  rdata;
  } state_t;

  state_t      r;
  state_t      n;
  logic [7:0]  src;
  logic [1:0]  div_level;
  logic        fb_level;
  logic [3:0]  shifted;
  logic        setup;
  logic        access;
  logic        mapped;

  // ********************************************************************
  // combinational helpers
  // ********************************************************************
  assign src = {r.edge_sync[1][1], r.edge_sync[0][1], r.div_out[1], r.div_out[0],
                r.div3, r.secondary, r.adjusted, r.primary};
  assign shifted = r.phase_cnt + dynamic_phase_adjust;

  genvar g;
  generate
    for (g = 0; g < NUM_DIVIDERS; g++) begin : g_div_src
      assign div_level[g] = r.div_src[g] ? r.edge_sync[g][1] : r.primary;
    end
  endgenerate

  always_comb begin
    unique case (feedback_sel_t'(r.fb_sel))
      FB_INTERNAL:  fb_level = r.primary;
      FB_CLOCK_NET: fb_level = r.clock_net;
      FB_USER:      fb_level = r.fb_sync[1];
      FB_RESERVED:  fb_level = r.primary;
    endcase
  end

  assign setup  = psel & ~penable;
  assign access = psel & penable;
  assign mapped = (paddr[11:2] <= OFS_LINE_STATUS[11:2]) && (paddr[1:0] == 2'h0);

  function automatic logic [31:0] read_mux(input state_t s, input logic [11:0] a);
    logic [31:0] w;
    w = 32'h0000_0000;
    if (a == OFS_PLL_CTRL) begin
      w[PLL_RESET_BIT] = s.pll_reset;
      w[K_RESET_BIT] = s.k_reset;
      w[FB_SEL_LSB +: 2] = s.fb_sel;
      w[K_RATIO_LSB +: 4] = s.k_ratio;
    end else if (a == OFS_PLL_STATUS) begin
      w[3:0] = {s.secondary, s.adjusted, s.primary, s.lock};
    end else if (a == OFS_DIV_CTRL) begin
      for (int i = 0; i < NUM_DIVIDERS; i++) begin
        w[i*DIV_FIELD_W + DIV_RATIO_LSB +: 2] = s.div_ratio[i];
        w[i*DIV_FIELD_W + DIV_SRC_BIT] = s.div_src[i];
        w[i*DIV_FIELD_W + DIV_RESET_BIT] = s.div_reset[i];
        w[i*DIV_FIELD_W + DIV_HELD_BIT] = s.div_held[i];
      end
    end else if (a == OFS_CSEL_SELECT) begin
      w[7:0] = s.csel_sel;
    end else if (a[11:4] == OFS_QUAD_ROUTE[11:4]) begin
      w[23:0] = s.line_sel[a[3:2]];
      w[ROUTE_ALT_LSB +: 6] = s.alt_sel[a[3:2]];
    end else if (a == OFS_LINE_STATUS) begin
      w = s.lines;
    end
    return w;
  endfunction

  // ********************************************************************
  // next state
  // ********************************************************************
  always_comb begin
    n = r;

    // reference, feedback and edge clock pins pass two flops; only the second stage is read
    n.ref_sync = {r.ref_sync[0], pll_reference_in};
    n.fb_sync = {r.fb_sync[0], pll_feedback_in};
    for (int i = 0; i < NUM_DIVIDERS; i++) begin
      n.edge_sync[i] = {r.edge_sync[i][0], edge_fast_clock[i]};
    end
    n.ref_prev = r.ref_sync[1];
    n.fb_prev = fb_level;
    n.primary_prev = r.primary;
    n.div_src_prev = div_level;

    // read data prepared in the setup cycle so it comes from a flop
    if (setup) begin
      n.rdata = read_mux(r, paddr);
    end

    // register writes complete in the access cycle
    n.div_held = r.div_held;
    if (access && pwrite) begin
      if (paddr == OFS_PLL_CTRL) begin
        n.pll_reset = pwdata[PLL_RESET_BIT];
        n.k_reset = pwdata[K_RESET_BIT];
        n.fb_sel = pwdata[FB_SEL_LSB +: 2];
        n.k_ratio = pwdata[K_RATIO_LSB +: 4];
      end else if (paddr == OFS_DIV_CTRL) begin
        for (int i = 0; i < NUM_DIVIDERS; i++) begin
          n.div_ratio[i] = pwdata[i*DIV_FIELD_W + DIV_RATIO_LSB +: 2];
          n.div_src[i] = pwdata[i*DIV_FIELD_W + DIV_SRC_BIT];
          n.div_reset[i] = pwdata[i*DIV_FIELD_W + DIV_RESET_BIT];
          if (pwdata[i*DIV_FIELD_W + DIV_RELEASE_BIT] && !r.div_reset[i]) begin
            n.div_held[i] = 1'b0;
          end
        end
      end else if (paddr == OFS_CSEL_SELECT) begin
        n.csel_sel = pwdata[7:0];
      end else if (paddr[11:4] == OFS_QUAD_ROUTE[11:4]) begin
        n.line_sel[paddr[3:2]] = pwdata[23:0];
        n.alt_sel[paddr[3:2]] = pwdata[ROUTE_ALT_LSB +: 6];
      end
    end

    // pll core model: one output period is sixteen bus clocks
    if (r.pll_reset) begin
      n.phase_cnt = 4'h0;
      n.primary = 1'b0;
      n.lock_cnt = 4'h0;
      n.fb_seen = 1'b0;
      n.lock = 1'b0;
      n.div3_cnt = 2'h0;
      n.div3 = 1'b0;
    end else begin
      n.phase_cnt = r.phase_cnt + 4'h1;
      n.primary = ~r.phase_cnt[3]; // lags the count so the first pulse is full
      // a feedback edge in the same cycle as a reference edge still counts
      if (fb_level && !r.fb_prev) begin
        n.fb_seen = 1'b1;
      end
      if (r.ref_sync[1] && !r.ref_prev) begin
        n.fb_seen = 1'b0;
        if (r.fb_seen || (fb_level && !r.fb_prev)) begin
          if (r.lock_cnt != LOCK_EDGES) begin
            n.lock_cnt = r.lock_cnt + 4'h1;
          end
        end else begin
          n.lock_cnt = 4'h0;
        end
      end
      n.lock = (n.lock_cnt == LOCK_EDGES);
      // both primary edges counted, so three edges make one half period
      if (r.primary != r.primary_prev) begin
        if (r.div3_cnt == DIV3_LAST) begin
          n.div3_cnt = 2'h0;
          n.div3 = ~r.div3;
        end else begin
          n.div3_cnt = r.div3_cnt + 2'h1;
        end
      end
    end
    n.clock_net = r.primary;
    n.adjusted_raw = ~r.pll_reset && (shifted <= dynamic_duty_select);
    n.adjusted = fine_delay_adjust ? r.adjusted_raw : n.adjusted_raw;

    // secondary divider: divides primary by twice (ratio plus one)
    if (r.pll_reset || r.k_reset) begin
      n.k_cnt = 4'h0;
      n.secondary = 1'b0;
    end else if (r.primary && !r.primary_prev) begin
      if (r.k_cnt == r.k_ratio) begin
        n.k_cnt = 4'h0;
        n.secondary = ~r.secondary;
      end else begin
        n.k_cnt = r.k_cnt + 4'h1;
      end
    end

    // edge dividers; counter sits at zero while held so phase is repeatable
    for (int i = 0; i < NUM_DIVIDERS; i++) begin
      if (r.div_reset[i]) begin
        n.div_cnt[i] = 3'h0;
        n.div_held[i] = 1'b1;
      end else if (r.div_held[i]) begin
        n.div_cnt[i] = 3'h0;
      end else if (div_level[i] && !r.div_src_prev[i]) begin
        n.div_cnt[i] = r.div_cnt[i] + 3'h1;
      end
      unique case (r.div_ratio[i])
        RATIO_DIV2: n.div_out[i] = ~n.div_held[i] & n.div_cnt[i][0];
        RATIO_DIV4: n.div_out[i] = ~n.div_held[i] & n.div_cnt[i][1];
        RATIO_DIV8: n.div_out[i] = ~n.div_held[i] & n.div_cnt[i][2];
        default:    n.div_out[i] = ~n.div_held[i] & n.div_cnt[i][2];
      endcase
    end

    // glitchless selectors: old clock gated only while low,
    // new clock taken only after it falls, so a full low phase comes first;
    // a stopped new clock keeps the line low
    for (int j = 0; j < NUM_CSEL; j++) begin
      logic a_clk;
      logic b_clk;
      logic old_clk;
      logic new_clk;
      a_clk = src[r.line_sel[j/2][CSEL_FIRST_LINE + j%2]];
      b_clk = src[r.alt_sel[j/2][j%2]];
      old_clk = r.csel_cur[j] ? b_clk : a_clk;
      new_clk = r.csel_sel[j] ? b_clk : a_clk;
      unique case (r.csel_state[j])
        CSEL_FOLLOW: begin
          n.csel_armed[j] = 1'b0;
          if ((r.csel_sel[j] != r.csel_cur[j]) && !old_clk) begin
            n.csel_state[j] = CSEL_GATED;
          end
        end
        CSEL_GATED: begin
          if (new_clk) begin
            n.csel_armed[j] = 1'b1;
          end else if (r.csel_armed[j]) begin
            n.csel_cur[j] = r.csel_sel[j];
            n.csel_state[j] = CSEL_FOLLOW;
          end
        end
      endcase
      n.csel_out[j] = (n.csel_state[j] == CSEL_FOLLOW) &&
                      (n.csel_cur[j] ? b_clk : a_clk);
    end

    // primary lines: six fed from the central mux, two from selectors
    for (int q = 0; q < NUM_QUADS; q++) begin
      for (int l = 0; l < NUM_LINES; l++) begin
        if (l >= CSEL_FIRST_LINE) begin
          n.lines[q*NUM_LINES + l] = r.csel_out[q*2 + l - CSEL_FIRST_LINE];
        end else begin
          n.lines[q*NUM_LINES + l] = src[r.line_sel[q][l]];
        end
      end
    end
  end

  // ********************************************************************
  // registers
  // ********************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.pll_reset <= PLL_RESET_INIT;
      r.k_reset <= K_RESET_INIT;
      r.k_ratio <= K_RATIO_INIT;
      r.div_held <= {NUM_DIVIDERS{DIV_HELD_INIT}};
    end else begin
      r <= n;
    end
  end

  // ********************************************************************
  // outputs
  // ********************************************************************
  assign prdata                    = r.rdata;
  assign pready                    = 1'b1;
  assign pslverr                   = access & ~mapped;
  assign pll_primary_out           = r.primary;
  assign pll_adjusted_out          = r.adjusted;
  assign pll_secondary_divided_out = r.secondary;
  assign pll_div3_out              = r.div3;
  assign pll_lock                  = r.lock;
  assign divider_out               = r.div_out;
  assign primary_lines             = r.lines;

endmodule // pll_divider_clock_select

// File: test/fabric_partner.sv
// ********************************************************************
// fabric model: reference, feedback, edge clocks, adjust inputs
// ********************************************************************
module fabric_partner (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       fb_en,
  output logic            pll_reference_in,
  output logic            pll_feedback_in,
  output logic [1:0]      edge_fast_clock,
  output logic [3:0]      dynamic_phase_adjust,
  output logic [3:0]      dynamic_duty_select,
  output logic            fine_delay_adjust
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] cnt;
  logic [3:0] e0;
  logic [3:0] e1;
  logic [1:0] ref_d;
  // reference period 32 pclk: every level well above the two-cycle minimum
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt              <= 5'h00;
      e0               <= 4'h0;
      e1               <= 4'h0;
      ref_d            <= 2'h0;
      pll_reference_in <= 1'h0;
      pll_feedback_in  <= 1'h0;
      edge_fast_clock  <= 2'h0;
    end else begin
      cnt              <= cnt + 5'h01;
      pll_reference_in <= cnt[4];
      ref_d            <= {ref_d[0], pll_reference_in};
      pll_feedback_in  <= fb_en & ref_d[1];
      e0               <= (e0 == 4'h4) ? 4'h0 : e0 + 4'h1;
      e1               <= (e1 == 4'h5) ? 4'h0 : e1 + 4'h1;
      if (e0 == 4'h4) edge_fast_clock[0] <= ~edge_fast_clock[0];
      if (e1 == 4'h5) edge_fast_clock[1] <= ~edge_fast_clock[1];
    end
  end
  // static settings keep the adjusted output at half duty
  assign dynamic_phase_adjust = 4'h3;
  assign dynamic_duty_select  = 4'h7;
  assign fine_delay_adjust    = 1'h1;
endmodule // fabric_partner

// File: test/pll_clock_props.sv
// ********************************************************************
// checker
// ********************************************************************
module pll_clock_props
  import pll_clock_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        pll_primary_out,
  input wire logic        pll_adjusted_out,
  input wire logic        pll_secondary_divided_out,
  input wire logic        pll_div3_out,
  input wire logic        pll_lock,
  input wire logic [1:0]  divider_out,
  input wire logic [31:0] primary_lines
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       pll_rst_q;
  logic       k_rst_q;
  logic [1:0] held_q;
  wire        wr = psel && penable && pwrite && pready;
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // shadow of the control bits, taken at the access edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_rst_q <= 1'h0;
      k_rst_q   <= 1'h0;
      held_q    <= 2'h3;
    end else if (wr && paddr == OFS_PLL_CTRL) begin
      pll_rst_q <= pwdata[0];
      k_rst_q   <= pwdata[1];
    end else if (wr && paddr == OFS_DIV_CTRL) begin
      for (int i = 0; i < 2; i++) begin
        if (pwdata[8*i+3]) held_q[i] <= 1'h1;
        else if (pwdata[8*i+4]) held_q[i] <= 1'h0;
      end
    end
  end
  AST_PLL_RESET: assert property (pll_rst_q && $past(pll_rst_q, 2) |->
    !(pll_primary_out || pll_adjusted_out || pll_div3_out || pll_lock))
    else $error("pll outputs active under pll reset");
  AST_K_RESET: assert property (k_rst_q && $past(k_rst_q, 2) |->
    !pll_secondary_divided_out) else $error("secondary output active under k reset");
  AST_DIV3: assert property (disable iff (!presetn || pll_rst_q)
    $rose(pll_div3_out) |-> ##23 pll_div3_out ##1 !pll_div3_out)
    else $error("div3 high phase not 24 cycles");
  AST_PRIMARY: assert property (disable iff (!presetn || pll_rst_q)
    $rose(pll_primary_out) |-> pll_primary_out[*8] ##1 !pll_primary_out[*8] ##1 pll_primary_out)
    else $error("primary output shape wrong");
  AST_DIV_HELD: assert property ((held_q & $past(held_q) & divider_out) == 2'h0)
    else $error("divider output high while held");
  AST_READY: assert property (pready) else $error("pready low");
  AST_SLVERR: assert property (pslverr == (psel && penable &&
    (paddr > OFS_LINE_STATUS || paddr[1:0] != 2'h0))) else $error("pslverr wrong");
  AST_LINE_ROUTE: assert property (disable iff (!presetn || pll_rst_q)
    $rose(pll_primary_out) |-> ##[0:3] $rose(primary_lines[0]))
    else $error("line zero not following primary");
  AST_NO_RUNT_HIGH: assert property (disable iff (!presetn || pll_rst_q)
    $rose(primary_lines[6]) |-> primary_lines[6][*8]) else $error("short high on line six");
  AST_NO_RUNT_LOW: assert property (disable iff (!presetn || pll_rst_q)
    $fell(primary_lines[6]) |-> !primary_lines[6][*8]) else $error("short low on line six");
endmodule // pll_clock_props

bind pll_divider_clock_select pll_clock_props u_pll_clock_props (
  .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pready, .pslverr,
  .pll_primary_out, .pll_adjusted_out, .pll_secondary_divided_out, .pll_div3_out,
  .pll_lock, .divider_out, .primary_lines
);

// File: test/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import pll_clock_pkg::*;
  // ********************************************************************
  // wiring
  // ********************************************************************
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, fb_en, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, primary_lines, rd;
  logic        pll_reference_in, pll_feedback_in, fine_delay_adjust;
  logic [1:0]  edge_fast_clock, divider_out;
  logic [3:0]  dynamic_phase_adjust, dynamic_duty_select;
  logic        pll_primary_out, pll_adjusted_out, pll_secondary_divided_out;
  logic        pll_div3_out, pll_lock;
  logic [9:0]  probe;
  logic [7:0]  v;
  int          n_errors, n_compared, cycles, t;
  assign probe = {primary_lines[8], pll_lock, primary_lines[7:6], divider_out, pll_div3_out,
                  pll_secondary_divided_out, pll_adjusted_out, pll_primary_out};
  pll_divider_clock_select u_pll_divider_clock_select (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .pll_reference_in, .pll_feedback_in, .edge_fast_clock, .dynamic_phase_adjust,
    .dynamic_duty_select, .fine_delay_adjust, .pll_primary_out, .pll_adjusted_out,
    .pll_secondary_divided_out, .pll_div3_out, .pll_lock, .divider_out, .primary_lines
  );
  fabric_partner u_fabric_partner (
    .pclk, .presetn, .fb_en, .pll_reference_in, .pll_feedback_in, .edge_fast_clock,
    .dynamic_phase_adjust, .dynamic_duty_select, .fine_delay_adjust
  );
  // ********************************************************************
  // tasks
  // ********************************************************************
  task automatic complete_run();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask
  // bounded so a stuck output cannot hang the wait
  task automatic edge_wait(input int idx, input logic lvl, inout int p);
    int k;
    for (k = 0; k < 1000 && probe[idx] !== lvl; k++) begin
      @(posedge pclk);
      p++;
    end
  endtask
  task automatic meas(input int idx, input int exp, input string nm);
    int s;
    int p;
    s = 0;
    p = 0;
    edge_wait(idx, 1'h0, s);
    edge_wait(idx, 1'h1, s);
    edge_wait(idx, 1'h0, p);
    edge_wait(idx, 1'h1, p);
    check(nm, exp, p);
  endtask
  // ********************************************************************
  // clock, timeout, sequence
  // ********************************************************************
  initial begin
    pclk = 1'h0;
    forever #10 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      complete_run();
    end
  end
  initial begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    fb_en = 1'h1;
    presetn = 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, OFS_PLL_CTRL, 32'h0000_0000);
    check("pll_ctrl", 32'h0000_0000, rd);
    apb(1'h0, OFS_DIV_CTRL, 32'h0000_0000);
    check("div_ctrl", 32'h0000_2020, rd);
    apb(1'h0, 12'h024, 32'h0000_0000);
    check("slverr_hi", 32'h0000_0001, er);
    apb(1'h0, 12'h002, 32'h0000_0000);
    check("slverr_odd", 32'h0000_0001, er);
    t = 0;
    edge_wait(8, 1'h1, t);
    apb(1'h0, OFS_PLL_STATUS, 32'h0000_0000);
    check("lock_bit", 32'h0000_0001, rd[0]);
    meas(0, 16, "primary");
    meas(1, 16, "adjusted");
    meas(2, 32, "secondary_k0");
    meas(3, 48, "div3");
    apb(1'h1, OFS_PLL_CTRL, 32'h0000_0010);
    meas(2, 64, "secondary_k1");
    apb(1'h1, OFS_PLL_CTRL, 32'h0000_0012);
    meas(0, 16, "primary_k_reset");
    check("secondary_k_reset", 32'h0000_0000, pll_secondary_divided_out);
    apb(1'h1, OFS_PLL_CTRL, 32'h0000_0001);
    repeat (4) @(posedge pclk);
    check("lock_pll_reset", 32'h0000_0000, {pll_lock, pll_primary_out});
    apb(1'h1, OFS_PLL_CTRL, 32'h0000_0008);
    t = 0;
    edge_wait(8, 1'h1, t);
    check("lock_user_fb", 32'h0000_0001, pll_lock);
    fb_en <= 1'h0;
    edge_wait(8, 1'h0, t);
    check("unlock_no_fb", 32'h0000_0000, pll_lock);
    apb(1'h1, OFS_PLL_CTRL, 32'h0000_0004);
    edge_wait(8, 1'h1, t);
    check("lock_net_fb", 32'h0000_0001, pll_lock);
    fb_en <= 1'h1;
    for (int r = 0; r < 3; r++) begin
      v = 8'(r);
      apb(1'h1, OFS_DIV_CTRL, {16'h0000, v | 8'h08, v | 8'h08});
      apb(1'h0, OFS_DIV_CTRL, 32'h0000_0000);
      check("held", 32'h0000_2020, rd & 32'h0000_2020);
      check("div_low", 32'h0000_0000, divider_out);
      apb(1'h1, OFS_DIV_CTRL, {16'h0000, v, v});
      apb(1'h1, OFS_DIV_CTRL, {16'h0000, v | 8'h10, v | 8'h10});
      meas(4, 32 << r, "div0_period");
      meas(5, 32 << r, "div1_period");
      t = 0;
      repeat (64) begin
        @(posedge pclk);
        t += int'(divider_out[0] !== divider_out[1]);
      end
      check("div_align", 32'h0000_0000, t);
    end
    apb(1'h1, OFS_DIV_CTRL, 32'h0000_0C0C);
    apb(1'h1, OFS_DIV_CTRL, 32'h0000_0404);
    apb(1'h1, OFS_DIV_CTRL, 32'h0000_1414);
    meas(4, 20, "div0_edge");
    meas(5, 24, "div1_edge");
    apb(1'h1, OFS_QUAD_ROUTE, 32'h0300_0000);
    meas(6, 16, "line6_a");
    apb(1'h1, OFS_CSEL_SELECT, 32'h0000_0001);
    meas(6, 48, "line6_b");
    meas(7, 16, "line7_a");
    apb(1'h1, OFS_CSEL_SELECT, 32'h0000_0000);
    meas(6, 16, "line6_back");
    apb(1'h1, OFS_QUAD_ROUTE + 12'h004, 32'h0000_0003);
    meas(9, 48, "q1_line0");
    complete_run();
  end
endmodule // tb
